// ### logic/dmdt_pkg.sv
// Constants, register map and carrier structs of the dual multimode down timer
package dmdt_pkg;
  localparam logic [4:0] ADR_T0_CTRL = 5'h01;
  localparam logic [4:0] ADR_T1_CTRL = 5'h02;
  localparam logic [4:0] ADR_OUT_MODE = 5'h02;
  localparam logic [4:0] ADR_INT_CTL0 = 5'h03;
  localparam logic [4:0] ADR_INT_ROUTE = 5'h04;
  localparam logic [4:0] ADR_T0_LO = 5'h0F;
  localparam logic [4:0] ADR_T0_HI = 5'h10;
  localparam logic [4:0] ADR_T1_LO = 5'h11;
  localparam logic [4:0] ADR_T1_HI = 5'h12;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // Timer control byte layout
  localparam int CTL_RUN = 0;
  localparam int CTL_CSEL = 1;
  localparam int CTL_MODE = 4;
  localparam int CTL_CHG = 6;
  localparam int CTL_RD = 7;
  localparam logic [2:0] CSEL_CASCADE = 3'h0;
  localparam logic [2:0] CSEL_XTAL = 3'h1;
  localparam logic [2:0] CSEL_XTAL4 = 3'h2;
  localparam logic [2:0] CSEL_10K7 = 3'h3;
  localparam logic [2:0] CSEL_1K = 3'h4;
  localparam logic [2:0] CSEL_100 = 3'h5;
  localparam logic [2:0] CSEL_10 = 3'h6;
  localparam logic [1:0] XDIV_LAST = 2'h3;
  // Output drive, interrupt control and routing bits
  localparam int OM_INTERRUPT_OUT_PIN_HI = 0;
  localparam int OM_INTERRUPT_OUT_PIN_PP = 1;
  localparam int OM_MFO_HI = 2;
  localparam int OM_MFO_PP = 3;
  localparam int IC_EN0 = 0;
  localparam int IC_FLG0 = 6;
  localparam int RT_IRQ_MFO = 0;
  // Prescaler periods in ns and in CLOCK_IN cycles
  localparam longint CLK_HZ = 64'd250_000_000;
  localparam longint NS_PER_S = 64'd1_000_000_000;
  localparam longint T_10K7_NS = 64'd93_500;
  localparam longint T_1K_NS = 64'd1_000_000;
  localparam longint T_100_NS = 64'd10_000_000;
  localparam longint T_10_NS = 64'd100_000_000;
  localparam longint T_1_NS = 64'd1_000_000_000;
  localparam int CNT_10K7 = int'(T_10K7_NS * CLK_HZ / NS_PER_S);
  localparam int CNT_1K = int'(T_1K_NS * CLK_HZ / NS_PER_S);
  localparam int CNT_100 = int'(T_100_NS * CLK_HZ / NS_PER_S);
  localparam int CNT_10 = int'(T_10_NS * CLK_HZ / NS_PER_S);
  localparam int CNT_1 = int'(T_1_NS * CLK_HZ / NS_PER_S);

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_RATE = 2'h1,
    MODE_SQUARE = 2'h2,
    MODE_ONESHOT = 2'h3
  } dmdt_mode_e;

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [7:0] data;
    logic reg_sel;
    logic [1:0] gate;
    logic xtal;
  } dmdt_pins_s;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] latch;
    logic [27:0] pre;
    logic [1:0] xdiv;
    logic out;
    logic started;
    logic pend;
    logic trig_prev;
  } dmdt_tmr_s;

  typedef struct packed {
    dmdt_tmr_s t;
    logic irq;
    logic clr_run;
  } dmdt_step_s;

  typedef struct packed {
    dmdt_pins_s s1;
    dmdt_pins_s s2;
    logic rd_prev;
    logic wr_prev;
    logic xtal_prev;
    logic t1_out_prev;
    logic [1:0][7:0] ctrl;
    logic [1:0][15:0] preset;
    logic [7:0] out_mode;
    logic [7:0] int_ctl;
    logic [7:0] route;
    dmdt_tmr_s [1:0] tmr;
    logic [7:0] dout;
    logic doe;
    logic multifunction_out_pin;
    logic mfo_oe;
    logic interrupt_out_pin;
    logic interrupt_out_pin_oe;
  } dmdt_state_s;
endpackage

// ### logic/dmdt_top.sv
// Dual 16-bit multimode down timer with byte-wide host register port
// Operation
// - Two timers, 16-bit down counters, falling timer clock
// - Timer 0 drives multifunction pin; timer 1 internal
// - Data locations access presets by default
// - Two preset bytes, one control byte per timer
// - Load presets, count to zero, toggle, interrupt
// - Three-bit clock select picks eight sources
// - Timer 1 output clocking timer 0 cascades
// - Per-timer prescaler bounds start/stop error
// - Hold bit suspends modes 0-2, triggers mode 3
// - Sync error: one clock or 32 us
// - Two-bit mode field selects four modes
// - Mode 0: low stopped, load and rise
// - Mode 0: high N periods, then low
// - Mode 0: interrupt and clear run at zero
// - Hold bit or gate pin suspends counting in modes 0-2
// - Output pins programmable polarity and drive
// - Latch bit snapshots count; low read clears
`timescale 1ns/10ps
module dmdt_top #(
  parameter int unsigned DIV_10K7 = dmdt_pkg::CNT_10K7,
  parameter int unsigned DIV_1K = dmdt_pkg::CNT_1K,
  parameter int unsigned DIV_100 = dmdt_pkg::CNT_100,
  parameter int unsigned DIV_10 = dmdt_pkg::CNT_10,
  parameter int unsigned DIV_1 = dmdt_pkg::CNT_1
) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic CS_N_IN,
  input wire logic RD_N_IN,
  input wire logic WR_N_IN,
  input wire logic [4:0] ADDR_IN,
  input wire logic [7:0] DATA_IN,
  input wire logic REG_SEL_IN,
  input wire logic XTAL_IN,
  input wire logic TIMER0_GATE_PIN_IN,
  input wire logic TIMER1_GATE_PIN_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE_OUT,
  output logic MULTIFUNCTION_OUT_PIN_OUT,
  output logic MULTIFUNCTION_OUT_PIN_OE_OUT,
  output logic INTERRUPT_OUT_PIN_OUT,
  output logic INTERRUPT_OUT_PIN_OE_OUT
);
  dmdt_pkg::dmdt_state_s st_q;
  dmdt_pkg::dmdt_state_s st_d;
  dmdt_pkg::dmdt_pins_s pins;
  logic [1:0] tick_w;
  logic [1:0] hold_w;
  logic [1:0] zev_w;
  logic [1:0] wr_ctl_w;
  logic [1:0] restart_w;
  logic rd_done_w;
  logic wr_done_w;
  logic xfall_w;
  logic t1fall_w;

  assign pins = '{cs: ~CS_N_IN, rd: ~RD_N_IN, wr: ~WR_N_IN, addr: ADDR_IN, data: DATA_IN,
                  reg_sel: REG_SEL_IN, gate: {TIMER1_GATE_PIN_IN, TIMER0_GATE_PIN_IN},
                  xtal: XTAL_IN};

  // Divide count of the fixed-rate sources
  function automatic logic [27:0] lim_of(input logic [2:0] sel);
    case (sel)
      dmdt_pkg::CSEL_10K7: lim_of = 28'(DIV_10K7);
      dmdt_pkg::CSEL_1K: lim_of = 28'(DIV_1K);
      dmdt_pkg::CSEL_100: lim_of = 28'(DIV_100);
      dmdt_pkg::CSEL_10: lim_of = 28'(DIV_10);
      default: lim_of = 28'(DIV_1);
    endcase
  endfunction

  // Electrical pin value from logical level, polarity and drive type
  function automatic logic [1:0] drive_of(input logic lvl, input logic hi, input logic pp);
    logic e;
    e = hi ? lvl : ~lvl;
    drive_of = pp ? {e, 1'b1} : {1'b0, ~e};
  endfunction

  // One clock step of a timer core
  function automatic dmdt_pkg::dmdt_step_s step_f(input dmdt_pkg::dmdt_tmr_s t,
      input logic [7:0] ctl, input logic [15:0] pre, input logic hold, input logic tick);
    dmdt_pkg::dmdt_step_s r;
    dmdt_pkg::dmdt_mode_e mode;
    logic [15:0] cnt_n;
    r = '{t: t, irq: 1'b0, clr_run: 1'b0};
    mode = dmdt_pkg::dmdt_mode_e'(ctl[dmdt_pkg::CTL_MODE +: 2]);
    cnt_n = t.count - 16'h0001;
    r.t.trig_prev = hold;
    if (!ctl[dmdt_pkg::CTL_RUN]) begin
      r.t.out = 1'b0;
      r.t.started = 1'b0;
      r.t.pend = 1'b0;
    end else if (mode == dmdt_pkg::MODE_ONESHOT) begin
      // Trigger edge raises the output at once; load waits for the timer clock
      if (hold && !t.trig_prev) begin
        r.t.out = 1'b1;
        r.t.pend = 1'b1;
      end
      if (tick) begin
        if (t.pend) begin
          r.t.count = pre;
          r.t.started = 1'b1;
          r.t.pend = hold && !t.trig_prev;
        end else if (t.started) begin
          r.t.count = cnt_n;
          if (cnt_n == 16'h0000) begin
            r.t.out = 1'b0;
            r.t.started = 1'b0;
            r.irq = 1'b1;
          end
        end
      end
    end else if (tick && !hold) begin
      if (!t.started) begin
        r.t.count = pre;
        r.t.out = 1'b1;
        r.t.started = 1'b1;
      end else begin
        case (mode)
          dmdt_pkg::MODE_SINGLE: begin
            r.t.count = cnt_n;
            if (cnt_n == 16'h0000) begin
              r.t.out = 1'b0;
              r.t.started = 1'b0;
              r.irq = 1'b1;
              r.clr_run = 1'b1;
            end
          end
          dmdt_pkg::MODE_RATE: begin
            if (t.pend) begin
              r.t.count = pre;
              r.t.out = 1'b1;
              r.t.pend = 1'b0;
            end else begin
              r.t.count = cnt_n;
              if (cnt_n == 16'h0000) begin
                r.t.out = 1'b0;
                r.t.pend = 1'b1;
                r.irq = 1'b1;
              end
            end
          end
          default: begin
            if (t.count == 16'h0000) begin
              r.t.out = ~t.out;
              r.t.count = pre;
              r.irq = t.out;
            end else begin
              r.t.count = cnt_n;
            end
          end
        endcase
      end
    end
    step_f = r;
  endfunction

  always_comb begin
    dmdt_pkg::dmdt_step_s sr;
    logic [2:0] sel;
    logic [27:0] lim;
    logic irq_line;
    logic [1:0] pd;
    logic [4:0] a;
    logic [7:0] wd;
    logic rs;
    int j;
    st_d = st_q;
    sr = '0;
    sel = 3'h0;
    lim = 28'h0000000;
    pd = 2'h0;
    a = st_q.s2.addr;
    wd = st_q.s2.data;
    rs = st_q.s2.reg_sel;
    irq_line = 1'b0;
    j = 0;
    // Pins pass two flip-flops; only the second stage is looked at
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.rd_prev = st_q.s2.rd;
    st_d.wr_prev = st_q.s2.wr;
    st_d.xtal_prev = st_q.s2.xtal;
    st_d.t1_out_prev = st_q.tmr[1].out;
    rd_done_w = st_q.rd_prev && !st_q.s2.rd && st_q.s2.cs;
    wr_done_w = st_q.wr_prev && !st_q.s2.wr && st_q.s2.cs;
    xfall_w = st_q.xtal_prev && !st_q.s2.xtal;
    t1fall_w = st_q.t1_out_prev && !st_q.tmr[1].out;
    wr_ctl_w[0] = wr_done_w && a == dmdt_pkg::ADR_T0_CTRL && !rs;
    wr_ctl_w[1] = wr_done_w && a == dmdt_pkg::ADR_T1_CTRL && !rs;
    for (j = 0; j < 2; j++) begin
      sel = st_q.ctrl[j][dmdt_pkg::CTL_CSEL +: 3];
      lim = lim_of(sel);
      hold_w[j] = st_q.ctrl[j][dmdt_pkg::CTL_CHG] | st_q.s2.gate[j];
      // Prescaler restarts on stop and on hold outside mode 3 so a start is never late by a full period
      restart_w[j] = !st_q.ctrl[j][dmdt_pkg::CTL_RUN] ||
                     (hold_w[j] && st_q.ctrl[j][dmdt_pkg::CTL_MODE +: 2] != 2'h3);
      case (sel)
        dmdt_pkg::CSEL_CASCADE: tick_w[j] = (j == 0) && t1fall_w;
        dmdt_pkg::CSEL_XTAL: tick_w[j] = xfall_w;
        dmdt_pkg::CSEL_XTAL4: tick_w[j] = xfall_w && st_q.tmr[j].xdiv == dmdt_pkg::XDIV_LAST;
        default: tick_w[j] = !restart_w[j] && st_q.tmr[j].pre == lim - 28'h0000001;
      endcase
      sr = step_f(st_q.tmr[j], st_q.ctrl[j], st_q.preset[j], hold_w[j], tick_w[j]);
      st_d.tmr[j] = sr.t;
      zev_w[j] = sr.irq;
      if (restart_w[j] || st_q.tmr[j].pre == lim - 28'h0000001) begin
        st_d.tmr[j].pre = 28'h0000000;
      end else begin
        st_d.tmr[j].pre = st_q.tmr[j].pre + 28'h0000001;
      end
      if (restart_w[j]) begin
        st_d.tmr[j].xdiv = 2'h0;
      end else if (xfall_w) begin
        st_d.tmr[j].xdiv = st_q.tmr[j].xdiv + 2'h1;
      end
      if (sr.clr_run) begin
        st_d.ctrl[j][dmdt_pkg::CTL_RUN] = 1'b0;
      end
      if (wr_ctl_w[j]) begin
        st_d.ctrl[j] = wd;
        if (wd[dmdt_pkg::CTL_RD]) begin
          st_d.tmr[j].latch = st_q.tmr[j].count;
        end
      end
    end
    if (wr_done_w) begin
      case (a)
        dmdt_pkg::ADR_T0_LO: st_d.preset[0][7:0] = wd;
        dmdt_pkg::ADR_T0_HI: st_d.preset[0][15:8] = wd;
        dmdt_pkg::ADR_T1_LO: st_d.preset[1][7:0] = wd;
        dmdt_pkg::ADR_T1_HI: st_d.preset[1][15:8] = wd;
        dmdt_pkg::ADR_OUT_MODE: if (rs) st_d.out_mode = wd;
        dmdt_pkg::ADR_INT_CTL0: begin
          if (rs) begin
            st_d.int_ctl[dmdt_pkg::IC_EN0 +: 2] = wd[dmdt_pkg::IC_EN0 +: 2];
            st_d.int_ctl[dmdt_pkg::IC_FLG0 +: 2] = st_q.int_ctl[dmdt_pkg::IC_FLG0 +: 2] &
                                                  ~wd[dmdt_pkg::IC_FLG0 +: 2];
          end
        end
        dmdt_pkg::ADR_INT_ROUTE: if (!rs) st_d.route = wd;
        default: ;
      endcase
    end
    // Reading a low byte while latched returns the data locations to the presets
    if (rd_done_w && a == dmdt_pkg::ADR_T0_LO) begin
      st_d.ctrl[0][dmdt_pkg::CTL_RD] = 1'b0;
    end
    if (rd_done_w && a == dmdt_pkg::ADR_T1_LO) begin
      st_d.ctrl[1][dmdt_pkg::CTL_RD] = 1'b0;
    end
    // Zero events set after the clear so that a simultaneous event is kept
    st_d.int_ctl[dmdt_pkg::IC_FLG0 +: 2] = st_d.int_ctl[dmdt_pkg::IC_FLG0 +: 2] | zev_w;
    st_d.doe = st_q.s2.cs && st_q.s2.rd;
    case (a)
      dmdt_pkg::ADR_T0_CTRL: st_d.dout = rs ? dmdt_pkg::RD_UNMAPPED : st_q.ctrl[0];
      dmdt_pkg::ADR_T1_CTRL: st_d.dout = rs ? st_q.out_mode : st_q.ctrl[1];
      dmdt_pkg::ADR_INT_CTL0: st_d.dout = rs ? st_q.int_ctl : dmdt_pkg::RD_UNMAPPED;
      dmdt_pkg::ADR_INT_ROUTE: st_d.dout = rs ? dmdt_pkg::RD_UNMAPPED : st_q.route;
      dmdt_pkg::ADR_T0_LO: st_d.dout = st_q.ctrl[0][dmdt_pkg::CTL_RD] ?
                                       st_q.tmr[0].latch[7:0] : st_q.preset[0][7:0];
      dmdt_pkg::ADR_T0_HI: st_d.dout = st_q.ctrl[0][dmdt_pkg::CTL_RD] ?
                                       st_q.tmr[0].latch[15:8] : st_q.preset[0][15:8];
      dmdt_pkg::ADR_T1_LO: st_d.dout = st_q.ctrl[1][dmdt_pkg::CTL_RD] ?
                                       st_q.tmr[1].latch[7:0] : st_q.preset[1][7:0];
      dmdt_pkg::ADR_T1_HI: st_d.dout = st_q.ctrl[1][dmdt_pkg::CTL_RD] ?
                                       st_q.tmr[1].latch[15:8] : st_q.preset[1][15:8];
      default: st_d.dout = dmdt_pkg::RD_UNMAPPED;
    endcase
    irq_line = |(st_q.int_ctl[dmdt_pkg::IC_FLG0 +: 2] & st_q.int_ctl[dmdt_pkg::IC_EN0 +: 2]);
    // Timer 1 has no pin; routing may steer the interrupt onto the multifunction pin
    pd = drive_of(st_q.route[dmdt_pkg::RT_IRQ_MFO] ? irq_line : st_q.tmr[0].out,
                  st_q.out_mode[dmdt_pkg::OM_MFO_HI], st_q.out_mode[dmdt_pkg::OM_MFO_PP]);
    st_d.multifunction_out_pin = pd[1];
    st_d.mfo_oe = pd[0];
    pd = drive_of(irq_line && !st_q.route[dmdt_pkg::RT_IRQ_MFO],
                  st_q.out_mode[dmdt_pkg::OM_INTERRUPT_OUT_PIN_HI], st_q.out_mode[dmdt_pkg::OM_INTERRUPT_OUT_PIN_PP]);
    st_d.interrupt_out_pin = pd[1];
    st_d.interrupt_out_pin_oe = pd[0];
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign DATA_OUT = st_q.dout;
  assign DATA_OE_OUT = st_q.doe;
  assign MULTIFUNCTION_OUT_PIN_OUT = st_q.multifunction_out_pin;
  assign MULTIFUNCTION_OUT_PIN_OE_OUT = st_q.mfo_oe;
  assign INTERRUPT_OUT_PIN_OUT = st_q.interrupt_out_pin;
  assign INTERRUPT_OUT_PIN_OE_OUT = st_q.interrupt_out_pin_oe;

  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);

  sequence seq_t0_first_tick;
    st_q.ctrl[0][dmdt_pkg::CTL_RUN] && st_q.ctrl[0][5:4] != 2'h3 && tick_w[0] &&
    !hold_w[0] && !st_q.tmr[0].started;
  endsequence

  sequence seq_t0_loaded;
    st_q.tmr[0].out && st_q.tmr[0].started && st_q.tmr[0].count == $past(st_q.preset[0]);
  endsequence

  AST_LOAD_ON_START: assert property (seq_t0_first_tick |=> seq_t0_loaded)
    else $error("preset not loaded on first timer clock");
  AST_STOPPED_LOW: assert property (!st_q.ctrl[0][dmdt_pkg::CTL_RUN] |=> !st_q.tmr[0].out)
    else $error("stopped timer output not low");
  AST_DECREMENT: assert property (
      st_q.tmr[0].started && tick_w[0] && !hold_w[0] &&
      st_q.ctrl[0][5:4] == 2'h0 && st_q.ctrl[0][0] && st_q.tmr[0].count > 16'h0001
      |=> st_q.tmr[0].count == $past(st_q.tmr[0].count) - 16'h0001)
    else $error("counter did not decrement by one");
  AST_HOLD_FREEZE: assert property (
      st_q.tmr[1].started && hold_w[1] && st_q.ctrl[1][0] &&
      st_q.ctrl[1][5:4] != 2'h3 |=> $stable(st_q.tmr[1].count))
    else $error("count moved while held");
  AST_MODE0_RUN_CLEAR: assert property (
      zev_w[0] && st_q.ctrl[0][5:4] == 2'h0 && !wr_ctl_w[0]
      |=> !st_q.ctrl[0][dmdt_pkg::CTL_RUN] && !st_q.tmr[0].out)
    else $error("run bit not cleared at zero");
  AST_ZERO_FLAG: assert property (zev_w[1] |=> st_q.int_ctl[dmdt_pkg::IC_FLG0 + 1])
    else $error("zero event lost");
  AST_CASCADE_TICK: assert property (
      st_q.ctrl[0][3:1] == dmdt_pkg::CSEL_CASCADE && tick_w[0] |-> $fell(st_q.tmr[1].out))
    else $error("cascaded tick without timer 1 falling edge");
  AST_PRESCALE_RESTART: assert property (
      restart_w[0] |=> st_q.tmr[0].pre == 28'h0000000 && st_q.tmr[0].xdiv == 2'h0)
    else $error("prescaler not restarted");
  AST_LATCH_CLEAR: assert property (
      rd_done_w && st_q.s2.addr == dmdt_pkg::ADR_T1_LO && !wr_ctl_w[1]
      |=> !st_q.ctrl[1][dmdt_pkg::CTL_RD])
    else $error("latch bit survived low byte read");
  AST_READ_PRESET: assert property (
      st_q.s2.cs && st_q.s2.rd && st_q.s2.addr == dmdt_pkg::ADR_T0_HI &&
      !st_q.ctrl[0][dmdt_pkg::CTL_RD]
      |=> DATA_OE_OUT && DATA_OUT == $past(st_q.preset[0][15:8]))
    else $error("read did not return preset");
  AST_MFO_PUSH_PULL: assert property (
      !st_q.route[0] && st_q.out_mode[3:2] == 2'h3
      |=> MULTIFUNCTION_OUT_PIN_OE_OUT && MULTIFUNCTION_OUT_PIN_OUT == $past(st_q.tmr[0].out))
    else $error("multifunction pin not following timer 0");
endmodule

// ### testbench/dmdt_host_model.sv
// Host processor model driving the byte-wide register strobes
`timescale 1ns/10ps
module dmdt_host_model (
  input wire logic clk_in,
  input wire logic data_oe_in,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic [4:0] addr_out,
  output logic reg_sel_out,
  output logic [7:0] data_out
);
  initial begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    addr_out = 5'h00;
    reg_sel_out = 1'b0;
    data_out = 8'h5A;
  end
  // Strobe is lifted before chip select so the release is seen while selected
  task automatic access(input logic is_wr, input logic [4:0] a, input logic rs,
      input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_in);
    addr_out = a;
    reg_sel_out = rs;
    data_out = d;
    cs_n_out = 1'b0;
    wr_n_out = ~is_wr;
    rd_n_out = is_wr;
    repeat (3) @(posedge clk_in);
    while (!is_wr && data_oe_in !== 1'b1 && n < 8) begin
      @(posedge clk_in);
      n++;
    end
    @(negedge clk_in);
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    cs_n_out = 1'b1;
    data_out = ~d;  // A released bus never keeps its last value
    repeat (4) @(posedge clk_in);
  endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the dual down timer
`timescale 1ns/10ps
module testbench;
  localparam int XP = 16;
  logic clk, rst_n, xtal, g0, g1, cs_n, rd_n, wr_n, rs, doe, oe_prev;
  logic multifunction_out_pin, mfo_oe, interrupt_out_pin, interrupt_out_pin_oe, mfo_act, interrupt_out_pin_act;
  logic [4:0] addr;
  logic [7:0] din, dout, om, ctl, n;
  logic [7:0] exp_q[$];
  logic [7:0] cfg[4] = '{8'h0F, 8'h0A, 8'h05, 8'h00};
  logic [4:0] ra[12] = '{5'h01, 5'h02, 5'h02, 5'h03, 5'h04, 5'h0F, 5'h10, 5'h11, 5'h12,
      5'h05, 5'h01, 5'h03};
  logic [11:0] rr = 12'b010000001100;
  logic [7:0] pv[4];
  int per[8] = '{0, XP, 4 * XP, 5, 7, 9, 11, 13};
  int fails = 0, samples_checked = 0, cycles = 0;

  // Undriven open-drain level is taken as pulled high
  assign mfo_act = ((mfo_oe ? multifunction_out_pin : 1'b1) === om[2]);
  assign interrupt_out_pin_act = ((interrupt_out_pin_oe ? interrupt_out_pin : 1'b1) === om[0]);

  dmdt_top #(.DIV_10K7(5), .DIV_1K(7), .DIV_100(9), .DIV_10(11), .DIV_1(13)) dmdt_top_inst (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .CS_N_IN(cs_n), .RD_N_IN(rd_n), .WR_N_IN(wr_n),
    .ADDR_IN(addr), .DATA_IN(din), .REG_SEL_IN(rs), .XTAL_IN(xtal),
    .TIMER0_GATE_PIN_IN(g0), .TIMER1_GATE_PIN_IN(g1), .DATA_OUT(dout), .DATA_OE_OUT(doe),
    .MULTIFUNCTION_OUT_PIN_OUT(multifunction_out_pin), .MULTIFUNCTION_OUT_PIN_OE_OUT(mfo_oe),
    .INTERRUPT_OUT_PIN_OUT(interrupt_out_pin), .INTERRUPT_OUT_PIN_OE_OUT(interrupt_out_pin_oe));

  dmdt_host_model dmdt_host_model_inst (.clk_in(clk), .data_oe_in(doe), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .addr_out(addr), .reg_sel_out(rs), .data_out(din));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    xtal = 1'b0;
    forever begin
      repeat (XP / 2) @(negedge clk);
      xtal = ~xtal;
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic r, input logic [7:0] d);
    dmdt_host_model_inst.access(1'b1, a, r, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic r, input logic [7:0] e);
    exp_q.push_back(e);
    dmdt_host_model_inst.access(1'b0, a, r, 8'h00);
  endtask

  task automatic start(input logic [4:0] a, input logic [7:0] v);
    wr(a, 1'b0, v & 8'hFE);
    wr(a, 1'b0, v | 8'h01);
  endtask

  // Measures the first active phase of the multifunction pin in clock cycles
  task automatic pulse(input int lo, input int hi);
    int w0, w;
    w0 = 0;
    w = 0;
    while (mfo_act !== 1'b1 && w0 < 4000) begin
      @(negedge clk);
      w0++;
    end
    while (mfo_act === 1'b1 && w < 4000) begin
      @(negedge clk);
      w++;
    end
    check("active width in range", 16'(w >= lo && w <= hi), 16'h0001);
  endtask

  // Read results are compared in the order the reads were issued, away from the launching edge
  always @(negedge clk) begin
    if (doe === 1'b1 && oe_prev !== 1'b1) begin
      if (exp_q.size() == 0) check("unexpected read", 16'h0001, 16'h0000);
      else check("read data", {8'h00, dout}, {8'h00, exp_q.pop_front()});
    end
    oe_prev <= doe;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    g0 = 1'b0;
    g1 = 1'b0;
    om = 8'h00;
    void'($urandom(25787));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check("mfo enable after reset", mfo_oe, 16'h0000);
    check("interrupt_out_pin enable after reset", interrupt_out_pin_oe, 16'h0000);
    for (int i = 0; i < 12; i++) rd(ra[i], rr[i], 8'h00);
    for (int i = 0; i < 4; i++) begin
      pv[i] = 8'($urandom);
      wr(dmdt_pkg::ADR_T0_LO + 5'(i), 1'b0, pv[i]);
    end
    for (int i = 0; i < 4; i++) rd(dmdt_pkg::ADR_T0_LO + 5'(i), 1'b0, pv[i]);
    wr(5'h05, 1'b0, 8'hFF);
    rd(5'h05, 1'b0, 8'h00);
    wr(dmdt_pkg::ADR_T1_CTRL, 1'b0, 8'h7E);
    rd(dmdt_pkg::ADR_T1_CTRL, 1'b0, 8'h7E);
    wr(dmdt_pkg::ADR_T1_CTRL, 1'b0, 8'h00);
    // Mode 0 over every fixed source and every pin polarity and drive
    for (int c = 1; c < 8; c++) begin
      om = cfg[c % 4];
      n = 8'(2 + $urandom_range(3));
      wr(dmdt_pkg::ADR_OUT_MODE, 1'b1, om);
      wr(dmdt_pkg::ADR_INT_CTL0, 1'b1, 8'h01);
      wr(dmdt_pkg::ADR_T0_LO, 1'b0, n);
      wr(dmdt_pkg::ADR_T0_HI, 1'b0, 8'h00);
      check("output idle while stopped", mfo_act, 16'h0000);
      ctl = {4'h0, 3'(c), 1'b0};
      fork
        start(dmdt_pkg::ADR_T0_CTRL, ctl);
        pulse(int'(n) * per[c] - 2, int'(n) * per[c] + 2);
      join
      repeat (4) @(negedge clk);
      check("interrupt pin active", interrupt_out_pin_act, 16'h0001);
      rd(dmdt_pkg::ADR_INT_CTL0, 1'b1, 8'h41);
      rd(dmdt_pkg::ADR_T0_CTRL, 1'b0, ctl);
      wr(dmdt_pkg::ADR_INT_CTL0, 1'b1, 8'h41);
      check("interrupt pin idle", interrupt_out_pin_act, 16'h0000);
    end
    // Finished counter holds zero while the preset still holds n
    wr(dmdt_pkg::ADR_T0_CTRL, 1'b0, 8'h80);
    rd(dmdt_pkg::ADR_T0_HI, 1'b0, 8'h00);
    rd(dmdt_pkg::ADR_T0_LO, 1'b0, 8'h00);
    rd(dmdt_pkg::ADR_T0_LO, 1'b0, n);
    rd(dmdt_pkg::ADR_T0_CTRL, 1'b0, 8'h00);
    // Gate pin held for 40 cycles stretches the pulse by that much, within one tick
    wr(dmdt_pkg::ADR_T0_LO, 1'b0, 8'h05);
    fork
      start(dmdt_pkg::ADR_T0_CTRL, 8'h02);
      pulse(5 * XP + 40 - XP - 2, 5 * XP + 40 + XP + 2);
      begin
        repeat (70) @(negedge clk);
        g0 = 1'b1;
        repeat (40) @(negedge clk);
        g0 = 1'b0;
      end
    join
    // Modes 1 to 3 on the period-5 source with a preset of 3
    // Rate mode is high for N ticks, square wave for N+1, one-shot N after trigger sync
    wr(dmdt_pkg::ADR_T0_LO, 1'b0, 8'h03);
    for (int m = 1; m < 4; m++) begin
      ctl = {2'b00, 2'(m), 3'h3, 1'b0};
      fork
        start(dmdt_pkg::ADR_T0_CTRL, ctl);
        pulse(m == 2 ? 18 : 13, m == 1 ? 17 : 22);
        if (m == 3) begin
          repeat (40) @(negedge clk);
          g0 = 1'b1;
          repeat (6) @(negedge clk);
          g0 = 1'b0;
        end
      join
      wr(dmdt_pkg::ADR_T0_CTRL, 1'b0, ctl);
    end
    // Timer 1 square wave of period 4 crystal cycles clocks timer 0
    wr(dmdt_pkg::ADR_T1_LO, 1'b0, 8'h01);
    wr(dmdt_pkg::ADR_T1_HI, 1'b0, 8'h00);
    wr(dmdt_pkg::ADR_T0_LO, 1'b0, 8'h02);
    start(dmdt_pkg::ADR_T1_CTRL, 8'h22);
    repeat (30) @(negedge clk);
    // Timer 1 gate pin freezes its count in mid-run
    g1 = 1'b1;
    repeat (40) @(negedge clk);
    g1 = 1'b0;
    repeat (30) @(negedge clk);
    check("pin quiet with timer 1 only", mfo_act, 16'h0000);
    fork
      start(dmdt_pkg::ADR_T0_CTRL, 8'h00);
      pulse(8 * XP - XP, 8 * XP + XP);
    join
    repeat (10) @(negedge clk);
    check("reads pending", 16'(exp_q.size()), 16'h0000);
    end_of_test();
  end
endmodule
